/* File: design/gpe_consts.svh */
// Purpose: Offsets, field positions, reset values for the GPIO edge block
// Assumes: Register indices are word indices; byte address = index * 4
// Notes:   Definitions only
// Summary of operation
// - Active edge on input pin sets flag
// - Write one clears flag, zero keeps
// - Flag and enable both set raise request
// - Eight flags, reset zero, always accessible
// - Data read: output value or live pin
// - Readback always shows pins, ignores writes
// - Only bits 7:6 exist, rest read zero
// - Direction zero input, one output
// - Readback may lag direction two cycles
// - Reduced drive one, ignored for inputs
// - Pull enable acts only on inputs
// - Polarity zero falling/pull-up, one rising/pull-down
// - Enable zero masks flag, one allows
// - Narrow port has per-pin interrupt enable
`ifndef GPE_CONSTS_SVH
`define GPE_CONSTS_SVH

`define GPE_IDX_WIDE_POL     6'h1D
`define GPE_IDX_WIDE_IEN     6'h1E
`define GPE_IDX_WIDE_FLAGS   6'h1F
`define GPE_IDX_NAR_DATA     6'h28
`define GPE_IDX_NAR_READBACK 6'h29
`define GPE_IDX_NAR_DIR      6'h2A
`define GPE_IDX_NAR_DRIVE    6'h2B
`define GPE_IDX_NAR_PULL     6'h2C
`define GPE_IDX_NAR_POL      6'h2D
`define GPE_IDX_NAR_IEN      6'h2E
`define GPE_IDX_NAR_FLAGS    6'h2F

`define GPE_NAR_LSB          3'd6
`define GPE_NAR_MSB          3'd7
`define GPE_RST_BYTE         8'h00
`define GPE_RST_NAR          2'h0
`define GPE_SYNC_STAGES      2
`define GPE_RESP_OKAY        2'h0
`define GPE_RESP_SLVERR      2'h2

`endif

/* File: design/gpe_pkg.sv */
// Purpose: Shared types for the GPIO edge block
// Assumes: Constants live in gpe_consts.svh
// Notes:   One-hot write channel states
package gpe_pkg;
   typedef logic [7:0] gpe_byte_t;
   typedef logic [5:0] gpe_idx_t;
   typedef enum logic [1:0] {
      GPE_WR_IDLE = 2'b01,
      GPE_WR_RESP = 2'b10
   } gpe_wr_state_t;
endpackage

/* File: design/gpe_edge_if.sv */
// Purpose: Carrier between the edge detector and the register core
// Assumes: One clock domain
// Notes:   Level is the synchronised pin level
`timescale 1ns/10ps
interface gpe_edge_if #(parameter int N = 8);
   logic [N-1:0] polarity;
   logic [N-1:0] level;
   logic [N-1:0] edge_hit;
   modport detect (input polarity, output level, output edge_hit);
   modport core   (output polarity, input level, input edge_hit);
endinterface

/* File: design/gpe_pin_sync.sv */
// Purpose: Two-flop pin synchroniser and polarity-selected edge detector
// Assumes: Pins are asynchronous to aclk
// Notes:   Edge pulse lasts one cycle per transition
`timescale 1ns/10ps
module gpe_pin_sync #(
   parameter int N = 8
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Raw pins
   input  wire logic [N-1:0] pin_raw,
   // Core side
   gpe_edge_if.detect        edge_bus
);
   logic [N-1:0] sync_a;
   logic [N-1:0] sync_b;
   logic [N-1:0] sync_prev;

   // First stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a    <= '0;
         sync_b    <= '0;
         sync_prev <= '0;
      end else begin
         sync_a    <= pin_raw;
         sync_b    <= sync_a;
         sync_prev <= sync_b;
      end
   end

   assign edge_bus.level = sync_b;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         // Polarity one: rising, zero: falling
         assign edge_bus.edge_hit[g] = edge_bus.polarity[g] ?
            (sync_b[g] & ~sync_prev[g]) :
            (~sync_b[g] & sync_prev[g]);
      end
   endgenerate
endmodule

/* File: design/gpe_port_top.sv */
// Purpose: Two-pin port and eight-pin port edge flags behind AXI4-Lite
// Assumes: Single 40 MHz clock, registers one per aligned word
// Notes:   Unmapped addresses answer SLVERR, reads of them return zero
`timescale 1ns/10ps
`include "gpe_consts.svh"
module gpe_port_top
   import gpe_pkg::*;
#(
   parameter int AW = 8,
   parameter int WN = 8,
   parameter int NN = 2
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // AXI4-Lite write address
   input  wire logic [AW-1:0] awaddr,
   input  wire logic [2:0]    awprot,
   input  wire logic          awvalid,
   output      logic          awready,
   // AXI4-Lite write data
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output      logic          wready,
   // AXI4-Lite write response
   output      logic [1:0]    bresp,
   output      logic          bvalid,
   input  wire logic          bready,
   // AXI4-Lite read address
   input  wire logic [AW-1:0] araddr,
   input  wire logic [2:0]    arprot,
   input  wire logic          arvalid,
   output      logic          arready,
   // AXI4-Lite read data
   output      logic [31:0]   rdata,
   output      logic [1:0]    rresp,
   output      logic          rvalid,
   input  wire logic          rready,
   // Eight-pin port inputs
   input  wire logic [WN-1:0] wide_pin_in,
   // Two-pin port pins (bits 7:6)
   input  wire logic [NN-1:0] nar_pin_in,
   output      logic [NN-1:0] nar_pin_out,
   output      logic [NN-1:0] nar_pin_oe,
   output      logic [NN-1:0] nar_reduced_drive,
   output      logic [NN-1:0] nar_pull_active,
   output      logic [NN-1:0] nar_pull_down,
   // Interrupt requests
   output      logic          irq_wide,
   output      logic          irq_narrow,
   output      logic          irq
);

   gpe_edge_if #(.N(WN)) wide_edge ();
   gpe_edge_if #(.N(NN)) nar_edge ();

   gpe_pin_sync #(.N(WN)) u_wide_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_raw  (wide_pin_in),
      .edge_bus (wide_edge.detect)
   );

   gpe_pin_sync #(.N(NN)) u_nar_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_raw  (nar_pin_in),
      .edge_bus (nar_edge.detect)
   );

   // Software-visible state
   logic [WN-1:0] wide_polarity_reg;
   logic [WN-1:0] wide_port_irq_enable;
   logic [WN-1:0] wide_port_irq_flags;
   logic [NN-1:0] narrow_port_data_reg;
   logic [NN-1:0] narrow_port_direction_reg;
   logic [NN-1:0] narrow_port_drive_reg;
   logic [NN-1:0] narrow_port_pull_enable_reg;
   logic [NN-1:0] narrow_port_polarity_reg;
   logic [NN-1:0] narrow_port_irq_enable;
   logic [NN-1:0] narrow_port_irq_flags;

   // Write channel state
   gpe_wr_state_t wr_state;
   logic          aw_held;
   logic          w_held;
   gpe_idx_t      aw_idx;
   logic          aw_bad;
   gpe_byte_t     w_byte;
   logic          w_lane0;
   logic          do_write;
   logic          wr_hit;
   logic [WN-1:0] wide_clear;
   logic [NN-1:0] nar_clear;
   logic [NN-1:0] nar_pin_now;
   gpe_byte_t     next_rdata;
   logic          next_rhit;
   gpe_idx_t      ar_idx;

   assign wide_edge.polarity = wide_polarity_reg;
   assign nar_edge.polarity  = narrow_port_polarity_reg;

   // Write address and data may arrive in either order
   assign awready  = (wr_state == GPE_WR_IDLE) && !aw_held;
   assign wready   = (wr_state == GPE_WR_IDLE) && !w_held;
   assign do_write = (wr_state == GPE_WR_IDLE) && aw_held && w_held;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_idx  <= '0;
         aw_bad  <= 1'b0;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         aw_idx  <= awaddr[7:2];
         aw_bad  <= (awaddr[1:0] != 2'h0);
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held  <= 1'b0;
         w_byte  <= `GPE_RST_BYTE;
         w_lane0 <= 1'b0;
      end else if (wvalid && wready) begin
         w_held  <= 1'b1;
         w_byte  <= wdata[7:0];
         w_lane0 <= wstrb[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // Only byte lane 0 carries register data
   function automatic logic idx_mapped(input gpe_idx_t idx);
      return (idx == `GPE_IDX_WIDE_POL)     ||
             (idx == `GPE_IDX_WIDE_IEN)     ||
             (idx == `GPE_IDX_WIDE_FLAGS)   ||
             (idx == `GPE_IDX_NAR_DATA)     ||
             (idx == `GPE_IDX_NAR_READBACK) ||
             (idx == `GPE_IDX_NAR_DIR)      ||
             (idx == `GPE_IDX_NAR_DRIVE)    ||
             (idx == `GPE_IDX_NAR_PULL)     ||
             (idx == `GPE_IDX_NAR_POL)      ||
             (idx == `GPE_IDX_NAR_IEN)      ||
             (idx == `GPE_IDX_NAR_FLAGS);
   endfunction

   assign wr_hit = do_write && w_lane0 && !aw_bad;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= GPE_WR_IDLE;
         bvalid   <= 1'b0;
         bresp    <= `GPE_RESP_OKAY;
      end else begin
         case (wr_state)
            GPE_WR_IDLE: begin
               if (do_write) begin
                  wr_state <= GPE_WR_RESP;
                  bvalid   <= 1'b1;
                  bresp    <= (idx_mapped(aw_idx) && !aw_bad) ?
                              `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
               end
            end
            GPE_WR_RESP: begin
               if (bready) begin
                  wr_state <= GPE_WR_IDLE;
                  bvalid   <= 1'b0;
               end
            end
            default: begin
               wr_state <= GPE_WR_IDLE;
               bvalid   <= 1'b0;
            end
         endcase
      end
   end

   // Eight-pin port configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wide_polarity_reg    <= '0;
         wide_port_irq_enable <= '0;
      end else if (wr_hit) begin
         if (aw_idx == `GPE_IDX_WIDE_POL) begin
            wide_polarity_reg <= w_byte[WN-1:0];
         end else if (aw_idx == `GPE_IDX_WIDE_IEN) begin
            wide_port_irq_enable <= w_byte[WN-1:0];
         end
      end
   end

   // Two-pin port configuration, bits 7:6 only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         narrow_port_data_reg        <= `GPE_RST_NAR;
         narrow_port_direction_reg   <= `GPE_RST_NAR;
         narrow_port_drive_reg       <= `GPE_RST_NAR;
         narrow_port_pull_enable_reg <= `GPE_RST_NAR;
         narrow_port_polarity_reg    <= `GPE_RST_NAR;
         narrow_port_irq_enable      <= `GPE_RST_NAR;
      end else if (wr_hit) begin
         if (aw_idx == `GPE_IDX_NAR_DATA) begin
            narrow_port_data_reg <= w_byte[`GPE_NAR_MSB:`GPE_NAR_LSB];
         end else if (aw_idx == `GPE_IDX_NAR_DIR) begin
            narrow_port_direction_reg <=
               w_byte[`GPE_NAR_MSB:`GPE_NAR_LSB];
         end else if (aw_idx == `GPE_IDX_NAR_DRIVE) begin
            narrow_port_drive_reg <= w_byte[`GPE_NAR_MSB:`GPE_NAR_LSB];
         end else if (aw_idx == `GPE_IDX_NAR_PULL) begin
            narrow_port_pull_enable_reg <=
               w_byte[`GPE_NAR_MSB:`GPE_NAR_LSB];
         end else if (aw_idx == `GPE_IDX_NAR_POL) begin
            narrow_port_polarity_reg <=
               w_byte[`GPE_NAR_MSB:`GPE_NAR_LSB];
         end else if (aw_idx == `GPE_IDX_NAR_IEN) begin
            narrow_port_irq_enable <=
               w_byte[`GPE_NAR_MSB:`GPE_NAR_LSB];
         end
      end
   end

   // Readback index accepts writes and drops them

   // Write-one-to-clear masks
   assign wide_clear = (wr_hit && aw_idx == `GPE_IDX_WIDE_FLAGS) ?
                       w_byte[WN-1:0] : '0;
   assign nar_clear  = (wr_hit && aw_idx == `GPE_IDX_NAR_FLAGS) ?
                       w_byte[`GPE_NAR_MSB:`GPE_NAR_LSB] : '0;

   // A new edge in the clearing cycle wins so no event is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wide_port_irq_flags <= '0;
      end else begin
         wide_port_irq_flags <= (wide_port_irq_flags & ~wide_clear) |
                                wide_edge.edge_hit;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         narrow_port_irq_flags <= `GPE_RST_NAR;
      end else begin
         narrow_port_irq_flags <= (narrow_port_irq_flags & ~nar_clear) |
                                  nar_edge.edge_hit;
      end
   end

   // Synchronised levels lag the pins, so readback trails direction
   // changes by up to two cycles
   assign nar_pin_now = nar_edge.level;

   // Read path: registered data, one cycle after address acceptance
   assign arready = !rvalid;
   assign ar_idx  = araddr[7:2];

   always_comb begin
      next_rdata = `GPE_RST_BYTE;
      next_rhit  = (araddr[1:0] == 2'h0);
      if (ar_idx == `GPE_IDX_WIDE_POL) begin
         next_rdata = wide_polarity_reg;
      end else if (ar_idx == `GPE_IDX_WIDE_IEN) begin
         next_rdata = wide_port_irq_enable;
      end else if (ar_idx == `GPE_IDX_WIDE_FLAGS) begin
         next_rdata = wide_port_irq_flags;
      end else if (ar_idx == `GPE_IDX_NAR_DATA) begin
         next_rdata = {(narrow_port_direction_reg & narrow_port_data_reg) |
                       (~narrow_port_direction_reg & nar_pin_now),
                       6'h00};
      end else if (ar_idx == `GPE_IDX_NAR_READBACK) begin
         next_rdata = {nar_pin_now, 6'h00};
      end else if (ar_idx == `GPE_IDX_NAR_DIR) begin
         next_rdata = {narrow_port_direction_reg, 6'h00};
      end else if (ar_idx == `GPE_IDX_NAR_DRIVE) begin
         next_rdata = {narrow_port_drive_reg, 6'h00};
      end else if (ar_idx == `GPE_IDX_NAR_PULL) begin
         next_rdata = {narrow_port_pull_enable_reg, 6'h00};
      end else if (ar_idx == `GPE_IDX_NAR_POL) begin
         next_rdata = {narrow_port_polarity_reg, 6'h00};
      end else if (ar_idx == `GPE_IDX_NAR_IEN) begin
         next_rdata = {narrow_port_irq_enable, 6'h00};
      end else if (ar_idx == `GPE_IDX_NAR_FLAGS) begin
         next_rdata = {narrow_port_irq_flags, 6'h00};
      end else begin
         next_rhit = 1'b0;
      end
      if (!next_rhit) begin
         next_rdata = `GPE_RST_BYTE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `GPE_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= {24'h00_0000, next_rdata};
         rresp  <= next_rhit ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // Pad controls; nar_pin_out and nar_pin_oe come straight from configuration flops
   assign nar_pin_out = narrow_port_data_reg;
   assign nar_pin_oe  = narrow_port_direction_reg;
   // Reduced drive means nothing while the pin is an input
   assign nar_reduced_drive = narrow_port_drive_reg &
                              narrow_port_direction_reg;
   // No wired-or mode here, so every output is push-pull and unpulled
   assign nar_pull_active = narrow_port_pull_enable_reg &
                            ~narrow_port_direction_reg;
   assign nar_pull_down   = narrow_port_polarity_reg;

   // Interrupt requests, level, one per port
   assign irq_wide   = |(wide_port_irq_flags &
                         wide_port_irq_enable);
   assign irq_narrow = |(narrow_port_irq_flags &
                         narrow_port_irq_enable);
   assign irq        = irq_wide | irq_narrow;

endmodule

/* File: sim/gpe_port_sva.sv */
// Purpose: Port-level assertions for the GPIO edge block
// Assumes: Bench offers write address and data together
// Notes:   Bound to gpe_port_top after the module
`timescale 1ns/10ps
`include "gpe_consts.svh"
module gpe_port_sva #(
   parameter int AW = 8,
   parameter int WN = 8,
   parameter int NN = 2
) (
   // Clock and reset
   input wire logic          aclk,
   input wire logic          aresetn,
   // Register bus
   input wire logic          awvalid,
   input wire logic          awready,
   input wire logic          wvalid,
   input wire logic          wready,
   input wire logic          bvalid,
   input wire logic [AW-1:0] araddr,
   input wire logic          arvalid,
   input wire logic          arready,
   input wire logic          rvalid,
   input wire logic [31:0]   rdata,
   input wire logic [1:0]    rresp,
   // Pins and requests
   input wire logic [WN-1:0] wide_pin_in,
   input wire logic [NN-1:0] nar_pin_oe,
   input wire logic [NN-1:0] nar_reduced_drive,
   input wire logic [NN-1:0] nar_pull_active,
   input wire logic          irq_wide,
   input wire logic          irq_narrow,
   input wire logic          irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_drive_masked: assert property ((nar_reduced_drive & ~nar_pin_oe) == '0)
      else $error("reduced drive seen on an input pin");
   chk_pull_inputs: assert property ((nar_pull_active & nar_pin_oe) == '0)
      else $error("pull device active on an output pin");
   chk_irq_join: assert property (irq == (irq_wide | irq_narrow))
      else $error("combined request differs from port requests");
   chk_wr_answer: assert property (awvalid && awready && wvalid && wready
      |-> ##[1:2] bvalid)
      else $error("write response late");
   chk_resp_quiet: assert property (bvalid |-> !awready && !wready)
      else $error("new write accepted while response pending");
   chk_rd_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   chk_rd_unmapped: assert property (arvalid && arready && araddr < 8'h74
      |=> rresp == `GPE_RESP_SLVERR && rdata == '0)
      else $error("unmapped read not refused");
   chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == '0)
      else $error("read data upper bits not zero");
   chk_irq_drop: assert property ($fell(irq_wide) |-> bvalid)
      else $error("wide request dropped without a write");
   // A pin change reaches the request three edges after it is sampled
   chk_irq_cause: assert property ($rose(irq_wide) |->
      $rose(bvalid) || $past(wide_pin_in, 3) != $past(wide_pin_in, 4))
      else $error("wide request rose without enable write or pin edge");
endmodule

bind gpe_port_top gpe_port_sva #(.AW(AW), .WN(WN), .NN(NN)) gpe_port_sva_inst (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
   .rresp(rresp), .wide_pin_in(wide_pin_in), .nar_pin_oe(nar_pin_oe),
   .nar_reduced_drive(nar_reduced_drive),
   .nar_pull_active(nar_pull_active), .irq_wide(irq_wide),
   .irq_narrow(irq_narrow), .irq(irq));

/* File: sim/gpe_pin_model.sv */
// Purpose: Far-side pins of both ports
// Assumes: Bench chooses external levels and whether they are driven
// Notes:   A narrow pin nobody drives or pulls flips every cycle
`timescale 1ns/10ps
module gpe_pin_model (
   // Clock
   input  wire logic       aclk,
   // Bench side
   input  wire logic [7:0] wide_drive,
   input  wire logic [1:0] ext_level,
   input  wire logic [1:0] ext_en,
   // Design side
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   input  wire logic [1:0] pull_active,
   input  wire logic [1:0] pull_down,
   output      logic [7:0] wide_pin,
   output      logic [1:0] nar_pin
);
   logic [1:0] float_level;
   assign wide_pin = wide_drive;
   // Known start so a float toggles instead of staying unknown
   initial float_level = 2'b00;
   // Inverted last level so a float never looks like a held value
   always @(posedge aclk) float_level <= ~nar_pin;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (pin_oe[i]) nar_pin[i] = pin_out[i];
         else if (ext_en[i]) nar_pin[i] = ext_level[i];
         else if (pull_active[i]) nar_pin[i] = ~pull_down[i];
         else nar_pin[i] = float_level[i];
      end
   end
endmodule

/* File: sim/gpe_port_top_bench.sv */
// Purpose: Self-checking bench for the GPIO edge block
// Assumes: Responses are taken with bready and rready held high
// Notes:   Pin effects are read four edges after a pin change
`timescale 1ns/10ps
`include "gpe_consts.svh"
module gpe_port_top_bench;
   import gpe_pkg::*;
   localparam logic [7:0] a_wpol = {`GPE_IDX_WIDE_POL, 2'b00};
   localparam logic [7:0] a_wien = {`GPE_IDX_WIDE_IEN, 2'b00};
   localparam logic [7:0] a_wflg = {`GPE_IDX_WIDE_FLAGS, 2'b00};
   localparam logic [7:0] a_data = {`GPE_IDX_NAR_DATA, 2'b00};
   localparam logic [7:0] a_rdbk = {`GPE_IDX_NAR_READBACK, 2'b00};
   localparam logic [7:0] a_dir  = {`GPE_IDX_NAR_DIR, 2'b00};
   localparam logic [7:0] a_drv  = {`GPE_IDX_NAR_DRIVE, 2'b00};
   localparam logic [7:0] a_pull = {`GPE_IDX_NAR_PULL, 2'b00};
   localparam logic [7:0] a_pol  = {`GPE_IDX_NAR_POL, 2'b00};
   localparam logic [7:0] a_nien = {`GPE_IDX_NAR_IEN, 2'b00};
   localparam logic [7:0] a_nflg = {`GPE_IDX_NAR_FLAGS, 2'b00};
   localparam logic [1:0] ok = `GPE_RESP_OKAY;
   localparam logic [1:0] err = `GPE_RESP_SLVERR;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready;
   logic        bvalid, arvalid, arready, rvalid, irq_wide, irq_narrow, irq;
   logic [7:0]  awaddr, araddr, wide_pin_in, wide_drive;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, nar_pin_in, nar_pin_out, nar_pin_oe;
   logic [1:0]  nar_reduced_drive, nar_pull_active, nar_pull_down;
   logic [1:0]  ext_level, ext_en;
   int          miscompares, checks_done, cycles;

   gpe_port_top gpe_port_top_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(1'b1), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(1'b1), .wide_pin_in(wide_pin_in), .nar_pin_in(nar_pin_in),
      .nar_pin_out(nar_pin_out), .nar_pin_oe(nar_pin_oe),
      .nar_reduced_drive(nar_reduced_drive),
      .nar_pull_active(nar_pull_active), .nar_pull_down(nar_pull_down),
      .irq_wide(irq_wide), .irq_narrow(irq_narrow), .irq(irq));
   gpe_pin_model gpe_pin_model_inst (
      .aclk(aclk), .wide_drive(wide_drive), .ext_level(ext_level),
      .ext_en(ext_en), .pin_out(nar_pin_out), .pin_oe(nar_pin_oe),
      .pull_active(nar_pull_active), .pull_down(nar_pull_down),
      .wide_pin(wide_pin_in), .nar_pin(nar_pin_in));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic conclude;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      cmp("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      cmp("rdata", {24'h00_0000, ed}, rdata);
      cmp("rresp", {30'h0, er}, {30'h0, rresp});
   endtask

   task automatic test_map;
      rd(a_wflg, 8'h00, ok);
      rd(8'h00, 8'h00, err);
      wr(8'h04, 8'h55, err);
   endtask

   task automatic test_wide;
      wr(a_wpol, 8'hff, ok);
      wide_drive <= 8'hff;
      tick(4);
      rd(a_wflg, 8'hff, ok);
      cmp("irq_wide", 0, irq_wide);
      wr(a_wien, 8'h01, ok);
      cmp("irq_wide", 1, irq_wide);
      cmp("irq", 1, irq);
      wr(a_wflg, 8'h0e, ok);
      rd(a_wflg, 8'hf1, ok);
      wr(a_wflg, 8'h01, ok);
      cmp("irq_wide", 0, irq_wide);
      wr(a_wflg, 8'hf0, ok);
      wide_drive <= 8'h0f;
      tick(4);
      rd(a_wflg, 8'h00, ok);
      wr(a_wpol, 8'h00, ok);
      wide_drive <= 8'h00;
      tick(4);
      rd(a_wflg, 8'h0f, ok);
      cmp("irq_wide", 1, irq_wide);
      wr(a_wflg, 8'h0f, ok);
      cmp("irq_wide", 0, irq_wide);
   endtask

   task automatic test_narrow_io;
      rd(a_data, 8'h80, ok);
      rd(a_rdbk, 8'h80, ok);
      wr(a_rdbk, 8'hff, ok);
      rd(a_rdbk, 8'h80, ok);
      wr(a_data, 8'h40, ok);
      wr(a_dir, 8'h40, ok);
      cmp("nar_pin_oe", 1, nar_pin_oe);
      cmp("nar_pin_out", 1, nar_pin_out);
      tick(3);
      rd(a_data, 8'hc0, ok);
      rd(a_rdbk, 8'hc0, ok);
      wr(a_drv, 8'hc0, ok);
      cmp("nar_reduced_drive", 1, nar_reduced_drive);
      wr(a_pull, 8'hc0, ok);
      cmp("nar_pull_active", 2, nar_pull_active);
      wr(a_pol, 8'h80, ok);
      cmp("nar_pull_down", 2, nar_pull_down);
   endtask

   task automatic test_narrow_irq;
      wr(a_nien, 8'hc0, ok);
      ext_en <= 2'b01;
      tick(4);
      rd(a_rdbk, 8'h40, ok);
      rd(a_nflg, 8'h00, ok);
      wr(a_pol, 8'h00, ok);
      tick(4);
      rd(a_rdbk, 8'hc0, ok);
      rd(a_nflg, 8'h00, ok);
      ext_en <= 2'b11;
      ext_level <= 2'b00;
      tick(4);
      rd(a_nflg, 8'h80, ok);
      cmp("irq_narrow", 1, irq_narrow);
      wr(a_nien, 8'h40, ok);
      cmp("irq_narrow", 0, irq_narrow);
      rd(a_nien, 8'h40, ok);
      wr(a_nflg, 8'h40, ok);
      rd(a_nflg, 8'h80, ok);
      wr(a_nflg, 8'h80, ok);
      rd(a_nflg, 8'h00, ok);
      cmp("irq", 0, irq);
   endtask

   initial begin
      aresetn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      wide_drive = 8'h00;
      ext_level = 2'b10;
      ext_en = 2'b11;
      tick(4);
      aresetn <= 1'b1;
      tick(1);
      test_map();
      test_wide();
      test_narrow_io();
      test_narrow_irq();
      conclude();
   end
endmodule
